// File: logic/dpbsp_defines.svh
/*
  Constants of the DDR pseudo-static DRAM slave port: command/address
  field positions, latency counts and burst sizing.
  Assumes it is included by bare name by the package and the host model.
*/
`ifndef DPBSP_DEFINES_SVH
`define DPBSP_DEFINES_SVH

// ----------------------------------------------------------------------
// command/address word layout
// ----------------------------------------------------------------------
`define DPBSP_CA_READ_BIT   47
`define DPBSP_CA_SPACE_BIT  46
`define DPBSP_CA_BURST_BIT  45
`define DPBSP_CA_ROW_HI     44
`define DPBSP_CA_ROW_LO     16
`define DPBSP_CA_COL_HI     2
`define DPBSP_CA_COL_LO     0
`define DPBSP_CA_LAST_EDGE  3'h5
`define DPBSP_BURST_LINEAR  1'b1

// ----------------------------------------------------------------------
// latency and burst sizing
// ----------------------------------------------------------------------
`define DPBSP_LAT_CLKS      6'h06
`define DPBSP_DUAL_DIE      1'b1
`define DPBSP_WRAP_BASE     32'h0000_0008
`define DPBSP_FIFO_DEPTH    16
`define DPBSP_WORD_BITS     16

`endif

// File: logic/dpbsp_pkg.sv
/*
  Types of the DDR pseudo-static DRAM slave port.
  Assumes the defines header sits beside it in logic/.
*/
`default_nettype none

package dpbsp_pkg;
  `include "dpbsp_defines.svh"

  typedef enum logic [1:0] {
    DPBSP_IDLE,
    DPBSP_CMD,
    DPBSP_LAT,
    DPBSP_XFER
  } dpbsp_phase_t;

  // one array write: word address, data, byte enables (high byte first)
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic [1:0]  be;
  } dpbsp_wr_word_t;

  typedef struct packed {
    logic       clk1, clk2, clk3;
    logic       cs1, cs2, cs3;
    logic [7:0] dq1, dq2;
    logic       msk1, msk2;
    logic       hr1, hr2;
  } dpbsp_sync_t;

  typedef struct packed {
    dpbsp_phase_t   phase;
    logic [2:0]     edge_cnt;
    logic [47:0]    ca;
    logic           is_read;
    logic           linear;
    logic [1:0]     wrap_sel;
    logic [5:0]     lat_cnt;
    logic [31:0]    addr;
    logic [31:0]    req_addr;
    logic [4:0]     outst;
    logic [4:0]     drop;
    logic [15:0]    word;
    logic [7:0]     wr_hi;
    logic           msk_hi;
    logic [7:0]     dq_out;
    logic           dq_drive;
    logic           strobe_out;
    logic           strobe_drive;
    logic           rd_req;
    logic [31:0]    rd_addr;
    logic           wr_valid;
    dpbsp_wr_word_t wr;
  } dpbsp_proto_t;

  typedef struct packed {
    dpbsp_sync_t  sy;
    dpbsp_proto_t p;
  } dpbsp_state_t;
endpackage

`default_nettype wire

// File: logic/dpbsp_fifo.sv
/*
  Read-data FIFO between the array and the link side of the slave port.
  Assumes one clock and a synchronous active-high reset; i_clear empties it.
*/
`timescale 1ns/1ps
`default_nettype none

module dpbsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_clear,
  input  wire logic                     i_in_valid,
  output logic                          o_in_ready,
  input  wire logic [WIDTH-1:0]         i_in_data,
  output logic                          o_out_valid,
  input  wire logic                     i_out_ready,
  output logic [WIDTH-1:0]              o_out_data,
  output logic [$clog2(DEPTH):0]        o_count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } dpbsp_fifo_state_t;

  dpbsp_fifo_state_t st;
  dpbsp_fifo_state_t next_st;

  assign o_count     = st.wr - st.rd;
  assign o_in_ready  = (o_count != DEPTH[AW:0]) && !i_clear;
  assign o_out_valid = (o_count != '0) && !i_clear;
  assign o_out_data  = st.mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (i_clear) begin
      next_st.wr = st.rd;
    end else begin
      if (i_in_valid && o_in_ready) begin
        next_st.mem[st.wr[AW-1:0]] = i_in_data;
        next_st.wr                 = st.wr + 1'b1;
      end
      if (o_out_valid && i_out_ready) begin
        next_st.rd = st.rd + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // dpbsp_fifo

`default_nettype wire

// File: logic/dpbsp_slave_port.sv
/*
  Slave-side transaction and burst logic of a pseudo-static DRAM on an
  8-bit double-data-rate bus: command/address capture, latency, wrapped
  and linear bursts, strobe/mask handling and array prefetch.
  Assumes the bus pins arrive asynchronously and are oversampled by
  i_ref_clk (well above twice the link clock), and that the array side
  answers read requests in order on i_arr_rd_valid.
*/
// Behaviour
// - every burst moves to the next 16-bit word each link clock
// - wrapped burst runs to group end, restarts at group start, returns to start
// - linear burst increments until chip select rises
// - burst type is taken from each transaction's own command
// - addresses resolve to 16-bit words only, never bytes
// - reads drive one word per clock, one byte per edge
// - writes capture one word per clock, one byte per edge
// - first two command cycles give row and burst type, then latency
// - strobe high during command phase when refresh is pending
// - third command cycle gives the start word within the row
// - linear mode prefetches ahead so row ends never stall
// - chip select fall starts, rise ends a transaction
// - link clock may stop between transactions; inverted clock optional
// - device drives strobe in command phase to report extra latency
// - read strobe transitions edge-aligned with read data
// - host drives strobe during write data as a byte mask
// - dual-die always uses doubled latency
// - hardware reset low reinitialises and returns to standby
// - hardware reset low releases strobe and all data lines
// - masked byte (strobe high) is discarded, unmasked byte written
// - command bit 45: 0 wrapped, 1 linear
`timescale 1ns/1ps
`default_nettype none

module dpbsp_slave_port
  import dpbsp_pkg::*;
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_sys_rst,
  input  wire logic           i_hw_rst_n,
  input  wire logic           i_cs_n,
  input  wire logic           i_interface_clk,
  input  wire logic           i_interface_clk_inverted,
  input  wire logic [7:0]     i_dq,
  output logic [7:0]          o_dq,
  output logic                o_dq_oe_n,
  input  wire logic           i_strobe_mask_line,
  output logic                o_strobe_mask_line,
  output logic                o_strobe_mask_line_oe_n,
  input  wire logic           i_refresh_pending,
  input  wire logic [1:0]     i_wrap_sel,
  output logic                o_arr_rd_req,
  output logic [31:0]         o_arr_rd_addr,
  input  wire logic           i_arr_rd_valid,
  input  wire logic [15:0]    i_arr_rd_data,
  output logic                o_arr_rd_ready,
  output logic                o_arr_wr_valid,
  output dpbsp_wr_word_t      o_arr_wr
);
  // --------------------------------------------------------------------
  // state and derived strobes
  // --------------------------------------------------------------------
  dpbsp_state_t st;
  dpbsp_state_t next_st;

  logic        link_rise;
  logic        link_fall;
  logic        link_edge;
  logic        cs_fall;
  logic        cs_rise;
  logic [31:0] wrap_mask;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [4:0]  fifo_count;
  logic        fifo_pop;
  logic        fifo_clear;
  logic        fifo_push;
  logic        resp;
  logic        reading;

  // only the second and third flops are looked at, never the first
  assign link_rise = st.sy.clk2 & ~st.sy.clk3;
  assign link_fall = ~st.sy.clk2 & st.sy.clk3;
  assign link_edge = link_rise | link_fall;
  assign cs_fall   = st.sy.cs3 & ~st.sy.cs2;
  assign cs_rise   = ~st.sy.cs3 & st.sy.cs2;

  // group size in words follows the setting caught at chip select fall
  assign wrap_mask = (`DPBSP_WRAP_BASE << st.p.wrap_sel) - 32'h0000_0001;

  assign reading   = st.p.is_read &&
                     (st.p.phase == DPBSP_LAT || st.p.phase == DPBSP_XFER);
  // stale answers from an ended burst are soaked up, never queued
  assign fifo_push      = i_arr_rd_valid && reading && (st.p.drop == 5'h00);
  assign o_arr_rd_ready = reading && (st.p.drop == 5'h00) ? fifo_in_ready : 1'b1;
  assign resp           = i_arr_rd_valid && o_arr_rd_ready;

  // --------------------------------------------------------------------
  // read-data buffer
  // --------------------------------------------------------------------
  dpbsp_fifo #(
    .WIDTH (`DPBSP_WORD_BITS),
    .DEPTH (`DPBSP_FIFO_DEPTH)
  ) u_rd_fifo (
    .i_clk       (i_ref_clk),
    .i_rst       (i_sys_rst),
    .i_clear     (fifo_clear),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_arr_rd_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out_data),
    .o_count     (fifo_count)
  );

  // word-granular step: linear carries on, wrapped stays inside the group
  function automatic logic [31:0] step_addr(input logic [31:0] a,
                                            input logic        lin,
                                            input logic [31:0] wmask);
    logic [31:0] inc;
    inc = a + 32'h0000_0001;
    return lin ? inc : ((a & ~wmask) | (inc & wmask));
  endfunction

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    logic [47:0] ca_new;
    logic        data_rise;
    logic        data_fall;
    logic        issue;
    logic [5:0]  credit;
    logic [15:0] rword;
    ca_new     = {st.p.ca[39:0], st.sy.dq2};
    data_rise  = link_rise && (st.p.phase == DPBSP_XFER ||
                 (st.p.phase == DPBSP_LAT && st.p.lat_cnt == 6'h00));
    data_fall  = link_fall && (st.p.phase == DPBSP_XFER);
    credit     = {1'b0, fifo_count} + {1'b0, st.p.outst};
    issue      = reading && !cs_rise && (credit < 6'h10);
    rword      = fifo_out_valid ? fifo_out_data : 16'h0000;
    fifo_pop   = 1'b0;
    fifo_clear = 1'b0;
    next_st    = st;

    // pin synchronisers; the inverted clock is optional and unused here
    next_st.sy.clk1 = i_interface_clk;
    next_st.sy.clk2 = st.sy.clk1;
    next_st.sy.clk3 = st.sy.clk2;
    next_st.sy.cs1  = i_cs_n;
    next_st.sy.cs2  = st.sy.cs1;
    next_st.sy.cs3  = st.sy.cs2;
    next_st.sy.dq1  = i_dq;
    next_st.sy.dq2  = st.sy.dq1;
    next_st.sy.msk1 = i_strobe_mask_line;
    next_st.sy.msk2 = st.sy.msk1;
    next_st.sy.hr1  = i_hw_rst_n;
    next_st.sy.hr2  = st.sy.hr1;

    next_st.p.rd_req   = 1'b0;
    next_st.p.wr_valid = 1'b0;

    // prefetch bookkeeping: every request holds a buffer slot until popped
    if (issue) begin
      next_st.p.rd_req   = 1'b1;
      next_st.p.rd_addr  = st.p.req_addr;
      next_st.p.req_addr = step_addr(st.p.req_addr, st.p.linear, wrap_mask);
    end
    next_st.p.outst = st.p.outst + {4'h0, issue} - {4'h0, resp};
    if (resp && st.p.drop != 5'h00) begin
      next_st.p.drop = st.p.drop - 5'h01;
    end

    if (cs_rise) begin
      next_st.p.phase        = DPBSP_IDLE;
      next_st.p.dq_drive     = 1'b0;
      next_st.p.strobe_drive = 1'b0;
      next_st.p.drop         = next_st.p.outst;
      fifo_clear             = 1'b1;
    end else if (cs_fall) begin
      next_st.p.phase        = DPBSP_CMD;
      next_st.p.edge_cnt     = 3'h0;
      next_st.p.wrap_sel     = i_wrap_sel;
      next_st.p.dq_drive     = 1'b0;
      next_st.p.strobe_drive = 1'b1;
      // dual-die always flags extra latency, so the line stays high
      next_st.p.strobe_out   = i_refresh_pending | `DPBSP_DUAL_DIE;
    end else begin
      unique case (st.p.phase)
        DPBSP_IDLE: begin
        end
        DPBSP_CMD: begin
          if (link_edge) begin
            next_st.p.ca       = ca_new;
            next_st.p.edge_cnt = st.p.edge_cnt + 3'h1;
            if (st.p.edge_cnt == `DPBSP_CA_LAST_EDGE) begin
              next_st.p.is_read  = ca_new[`DPBSP_CA_READ_BIT];
              next_st.p.linear   = (ca_new[`DPBSP_CA_BURST_BIT] == `DPBSP_BURST_LINEAR);
              // row/half-page from the first cycles, start word from the third
              next_st.p.addr     = {ca_new[`DPBSP_CA_ROW_HI:`DPBSP_CA_ROW_LO],
                                    ca_new[`DPBSP_CA_COL_HI:`DPBSP_CA_COL_LO]};
              next_st.p.req_addr = next_st.p.addr;
              next_st.p.phase    = DPBSP_LAT;
              next_st.p.lat_cnt  = (`DPBSP_LAT_CLKS << 1) - 6'h01;
              next_st.p.strobe_out   = 1'b0;
              next_st.p.strobe_drive = ca_new[`DPBSP_CA_READ_BIT];
            end
          end
        end
        DPBSP_LAT: begin
          if (link_rise && st.p.lat_cnt != 6'h00) begin
            next_st.p.lat_cnt = st.p.lat_cnt - 6'h01;
          end
          if (data_rise) begin
            next_st.p.phase = DPBSP_XFER;
          end
        end
        DPBSP_XFER: begin
        end
      endcase

      // data beats: high byte on the rising edge, low byte on the falling
      if (data_rise && st.p.is_read) begin
        fifo_pop             = fifo_out_valid;
        next_st.p.word       = rword;
        next_st.p.dq_out     = rword[15:8];
        next_st.p.dq_drive   = 1'b1;
        next_st.p.strobe_out = 1'b1;
      end
      if (data_fall && st.p.is_read) begin
        next_st.p.dq_out     = st.p.word[7:0];
        next_st.p.strobe_out = 1'b0;
        next_st.p.addr       = step_addr(st.p.addr, st.p.linear, wrap_mask);
      end
      if (data_rise && !st.p.is_read) begin
        next_st.p.wr_hi  = st.sy.dq2;
        next_st.p.msk_hi = st.sy.msk2;
      end
      if (data_fall && !st.p.is_read) begin
        next_st.p.wr_valid = 1'b1;
        next_st.p.wr.addr  = st.p.addr;
        next_st.p.wr.data  = {st.p.wr_hi, st.sy.dq2};
        next_st.p.wr.be    = {~st.p.msk_hi, ~st.sy.msk2};
        next_st.p.addr     = step_addr(st.p.addr, st.p.linear, wrap_mask);
      end
    end

    // hardware reset: back to standby with pins released; the answer
    // counter survives so late array answers are still soaked up
    if (!st.sy.hr2) begin
      next_st.p       = '0;
      next_st.p.outst = st.p.outst - {4'h0, resp};
      next_st.p.drop  = st.p.outst - {4'h0, resp};
      fifo_clear      = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign o_dq                    = st.p.dq_out;
  assign o_dq_oe_n               = ~st.p.dq_drive;
  assign o_strobe_mask_line      = st.p.strobe_out;
  assign o_strobe_mask_line_oe_n = ~st.p.strobe_drive;
  assign o_arr_rd_req            = st.p.rd_req;
  assign o_arr_rd_addr           = st.p.rd_addr;
  assign o_arr_wr_valid          = st.p.wr_valid;
  assign o_arr_wr                = st.p.wr;
endmodule // dpbsp_slave_port

`default_nettype wire

// File: tb/dpbsp_slave_port_asserts.sv
/*
  Port checker of the slave port, bound into every dpbsp_slave_port.
  Assumes a link clock of 64 ns against the 8 ns system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dpbsp_slave_port_asserts (
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_hw_rst_n,
  input wire logic       i_cs_n,
  input wire logic       i_interface_clk,
  input wire logic [7:0] o_dq,
  input wire logic       o_dq_oe_n,
  input wire logic       o_strobe_mask_line,
  input wire logic       o_strobe_mask_line_oe_n,
  input wire logic       o_arr_rd_req,
  input wire logic       o_arr_wr_valid
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------------
  property p_ca_strobe_high;
    $fell(i_cs_n) && i_hw_rst_n |-> ##[1:6] (!o_strobe_mask_line_oe_n && o_strobe_mask_line);
  endproperty
  a_ca_strobe_high: assert property (p_ca_strobe_high)
    else $error("strobe not driven high in command phase");

  property p_idle_release;
    i_cs_n [*6] |-> o_dq_oe_n && o_strobe_mask_line_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("pins still driven after chip select rose");

  property p_hw_release;
    !i_hw_rst_n [*5] |-> o_dq_oe_n && o_strobe_mask_line_oe_n;
  endproperty
  a_hw_release: assert property (p_hw_release)
    else $error("pins driven during hardware reset");

  property p_wr_spacing;
    o_arr_wr_valid |=> !o_arr_wr_valid [*7];
  endproperty
  a_wr_spacing: assert property (p_wr_spacing)
    else $error("more than one write word per link clock");

  property p_dq_with_strobe;
    !o_dq_oe_n && !$past(o_dq_oe_n) && $changed(o_dq) |-> $changed(o_strobe_mask_line);
  endproperty
  a_dq_with_strobe: assert property (p_dq_with_strobe)
    else $error("read data moved without a strobe edge");

  property p_strobe_follows_clk;
    !o_dq_oe_n && $changed(i_interface_clk) |-> ##[2:8] $changed(o_strobe_mask_line);
  endproperty
  a_strobe_follows_clk: assert property (p_strobe_follows_clk)
    else $error("no read byte for a link clock edge");

  property p_dq_needs_strobe;
    !o_dq_oe_n |-> !o_strobe_mask_line_oe_n;
  endproperty
  a_dq_needs_strobe: assert property (p_dq_needs_strobe)
    else $error("data driven while strobe released");

  property p_quiet_after_cs;
    i_cs_n [*8] |-> !o_arr_wr_valid;
  endproperty
  a_quiet_after_cs: assert property (p_quiet_after_cs)
    else $error("array write outside a transaction");

  property p_after_sys_rst;
    $past(i_sys_rst) |-> o_dq_oe_n && o_strobe_mask_line_oe_n && !o_arr_wr_valid && !o_arr_rd_req;
  endproperty
  a_after_sys_rst: assert property (p_after_sys_rst)
    else $error("outputs active right after reset");
endmodule // dpbsp_slave_port_asserts

bind dpbsp_slave_port dpbsp_slave_port_asserts u_asserts (
  .i_ref_clk, .i_sys_rst, .i_hw_rst_n, .i_cs_n, .i_interface_clk, .o_dq, .o_dq_oe_n,
  .o_strobe_mask_line, .o_strobe_mask_line_oe_n, .o_arr_rd_req, .o_arr_wr_valid);

`default_nettype wire

// File: tb/dpbsp_host_model.sv
/*
  Host bus master model: chip select, link clock, command bytes, write data.
  Assumes it resolves the shared data and strobe wires from both enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpbsp_defines.svh"

module dpbsp_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_dev_dq,
  input  wire logic       i_dev_dq_oe_n,
  input  wire logic       i_dev_strobe,
  input  wire logic       i_dev_strobe_oe_n,
  output logic            o_cs_n,
  output logic            o_link_clk,
  output logic            o_link_clk_n,
  output logic [7:0]      o_dq,
  output logic            o_strobe
);
  logic [7:0] dq_h;
  logic       s_h, dq_drv, s_drv, flt, prev_s;
  logic [7:0] got[$];

  initial begin
    o_cs_n = 1'b1;
    o_link_clk = 1'b0;
    {dq_h, s_h, dq_drv, s_drv, flt, prev_s} = '0;
  end
  assign o_link_clk_n = ~o_link_clk;
  // released wires toggle so a stale value can never pass for a driven one
  assign o_dq     = !i_dev_dq_oe_n ? i_dev_dq : dq_drv ? dq_h : {8{flt}};
  assign o_strobe = !i_dev_strobe_oe_n ? i_dev_strobe : s_drv ? s_h : flt;

  always @(negedge i_ref_clk) begin
    flt <= ~flt;
    prev_s <= i_dev_strobe;
    if (!i_dev_dq_oe_n && !i_dev_strobe_oe_n && i_dev_strobe !== prev_s) got.push_back(i_dev_dq);
  end

  // data set one cycle before the link edge, held three cycles after it
  task automatic half(input logic lvl, input logic [7:0] d, input logic m, input logic dd, input logic sd);
    dq_h = d;
    s_h = m;
    dq_drv = dd;
    s_drv = sd;
    @(negedge i_ref_clk);
    o_link_clk = lvl;
    repeat (3) @(negedge i_ref_clk);
  endtask

  task automatic xact(input logic rd, input logic lin, input logic [31:0] a, input int n,
                      input logic [15:0] wd, input logic [1:0] msk);
    logic [47:0] ca;
    logic [15:0] w;
    ca = {rd, 1'b0, lin, a[31:3], 13'h0000, a[2:0]};
    @(negedge i_ref_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    for (int k = 0; k < 6; k++) half(~k[0], ca[47-8*k -: 8], 1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 4*`DPBSP_LAT_CLKS-2; k++) half(~k[0], 8'h00, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      w = wd + 16'(i);
      half(1'b1, w[15:8], msk[1], !rd, !rd);
      half(1'b0, w[7:0], msk[0], !rd, !rd);
    end
    dq_drv = 1'b0;
    s_drv = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_ref_clk);
  endtask
endmodule // dpbsp_host_model

`default_nettype wire

// File: tb/test_dpbsp_slave_port.sv
/*
  Self-checking bench of the slave port with a host model and an array model.
  Assumes the checker is bound into the design by its own file.
*/
`timescale 1ns/1ps
`default_nettype none

module test_dpbsp_slave_port
  import dpbsp_pkg::*;
;
  logic           i_ref_clk, i_sys_rst, i_hw_rst_n, i_refresh_pending, arr_v, take;
  logic [1:0]     wrap_sel;
  logic [15:0]    arr_d;
  logic [7:0]     dev_dq, dq_w;
  logic           cs_n, lclk, lclk_n, s_w, dev_s, dq_oe_n, s_oe_n, rd_req, rd_ready, wr_v;
  logic [31:0]    rd_addr;
  logic [31:0]    aq[$];
  dpbsp_wr_word_t wr_word;
  dpbsp_wr_word_t wq[$];
  int             fails, comparisons, cycles;

  dpbsp_slave_port dut (
    .i_ref_clk, .i_sys_rst, .i_hw_rst_n, .i_cs_n(cs_n), .i_interface_clk(lclk),
    .i_interface_clk_inverted(lclk_n), .i_dq(dq_w), .o_dq(dev_dq), .o_dq_oe_n(dq_oe_n),
    .i_strobe_mask_line(s_w), .o_strobe_mask_line(dev_s), .o_strobe_mask_line_oe_n(s_oe_n),
    .i_refresh_pending, .i_wrap_sel(wrap_sel), .o_arr_rd_req(rd_req), .o_arr_rd_addr(rd_addr),
    .i_arr_rd_valid(arr_v), .i_arr_rd_data(arr_d), .o_arr_rd_ready(rd_ready),
    .o_arr_wr_valid(wr_v), .o_arr_wr(wr_word));

  dpbsp_host_model host (
    .i_ref_clk, .i_dev_dq(dev_dq), .i_dev_dq_oe_n(dq_oe_n), .i_dev_strobe(dev_s),
    .i_dev_strobe_oe_n(s_oe_n), .o_cs_n(cs_n), .o_link_clk(lclk), .o_link_clk_n(lclk_n),
    .o_dq(dq_w), .o_strobe(s_w));

  always #4 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------------------
  // array model: in-order answers, handshake judged from pre-edge values
  // ----------------------------------------------------------------------
  function automatic logic [15:0] mem_word(input logic [31:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction

  always @(negedge i_ref_clk) begin
    if (take) void'(aq.pop_front());
    if (rd_req) aq.push_back(rd_addr);
    if (wr_v) wq.push_back(wr_word);
    arr_v = aq.size() > 0;
    arr_d = arr_v ? mem_word(aq[0]) : 16'h0000;
    take = arr_v && rd_ready;
  end

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // checks and scenarios
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] burst_addr(input logic lin, input logic [1:0] sel, input logic [31:0] a, input int i);
    logic [31:0] m;
    m = (32'h0000_0008 << sel) - 32'h0000_0001;
    return lin ? a + 32'(i) : (a & ~m) | ((a + 32'(i)) & m);
  endfunction

  task automatic rd_burst(input logic lin, input logic [1:0] sel, input logic [31:0] a, input int n);
    wrap_sel = sel;
    host.got.delete();
    host.xact(1'b1, lin, a, n, 16'h0000, 2'b00);
    chk("read byte count", 32'(2*n), 32'(host.got.size()));
    for (int i = 0; i < n; i++)
      chk("read word", {16'h0000, mem_word(burst_addr(lin, sel, a, i))}, {16'h0000, host.got[2*i], host.got[2*i+1]});
  endtask

  task automatic wr_burst(input logic lin, input logic [31:0] a, input int n, input logic [15:0] wd, input logic [1:0] msk);
    wrap_sel = 2'h0;
    wq.delete();
    host.xact(1'b0, lin, a, n, wd, msk);
    chk("write count", 32'(n), 32'(wq.size()));
    for (int i = 0; i < n; i++) begin
      chk("write addr", burst_addr(lin, 2'h0, a, i), wq[i].addr);
      chk("write data", {16'h0000, wd + 16'(i)}, {16'h0000, wq[i].data});
      chk("write enables", {30'h0000_0000, ~msk}, {30'h0000_0000, wq[i].be});
    end
  endtask

  task automatic hw_reset_mid();
    host.got.delete();
    fork
      host.xact(1'b1, 1'b1, 32'h0000_0010, 2, 16'h0000, 2'b00);
      begin
        repeat (60) @(negedge i_ref_clk);
        i_hw_rst_n = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        chk("enables in reset", 32'h0000_0003, {30'h0000_0000, dq_oe_n, s_oe_n});
        i_hw_rst_n = 1'b1;
      end
    join
    chk("bytes after reset", 32'h0000_0000, 32'(host.got.size()));
  endtask

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {i_ref_clk, i_refresh_pending, arr_v, take, wrap_sel, arr_d} = '0;
    {fails, comparisons, cycles} = '0;
    i_sys_rst = 1'b1;
    i_hw_rst_n = 1'b1;
    repeat (5) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    for (int s = 0; s < 4; s++) rd_burst(1'b0, 2'(s), 32'h0000_0400 + (32'h0000_0008 << s) - 32'h0000_0002, 4);
    rd_burst(1'b0, 2'h0, 32'h0000_0126, 10);
    rd_burst(1'b1, 2'h0, 32'h0000_01fe, 6);
    i_refresh_pending = 1'b1;
    wr_burst(1'b0, 32'h0000_0037, 3, 16'hc3a0, 2'b00);
    wr_burst(1'b1, 32'h0000_003f, 3, 16'h1234, 2'b10);
    hw_reset_mid();
    rd_burst(1'b1, 2'h1, 32'h0000_0000, 3);
    complete_run();
  end
endmodule // test_dpbsp_slave_port

`default_nettype wire
